/* hdl/pxe_regs.vh */
// Constants for the serial-bus sixteen-bit port expander.
// Summary of operation
// - Start: data falls while clock high.
// - Stop: data rises while clock high; idle.
// - Address byte MSB first; LSB is direction.
// - Address is 0100 plus three strap bits.
// - General call address is never acknowledged.
// - Matching address acknowledged on ninth clock.
// - Reads shift out sampled port pin levels.
// - Write bytes become port output values.
// - Each written data byte is acknowledged.
// - Ports update after each acknowledged high-port byte, on clock rise.
// - One bit per clock; data changes while low.
// - Eight bits plus acknowledge, any byte count.
// - Transmitter releases data before acknowledge bit.
// - Acknowledge held low for whole clock high.
// - Master not-acknowledge ends read; device releases.
// - Stop mid-byte keeps outputs, drops partial data.
// - Bytes alternate low port then high port.
// - A trailing low-port byte without its high byte is dropped.
// - Reset returns bus state machine to idle.
`ifndef PXE_REGS_VH
`define PXE_REGS_VH
`define PXE_ADDR_HI 4'h4
`define PXE_GCALL_ADDR 7'h00
`define PXE_PORT_RST 16'hFFFF
`define PXE_BIT_LAST 3'h7
`define PXE_FIFO_DEPTH 32
`endif

/* hdl/pxe_fifo.v */
// Small synchronous FIFO holding received port words.
module pxe_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
    reg [AW-1:0] wptr_ff;
    reg [AW-1:0] rptr_ff;
    reg [AW:0] cnt_ff;
    wire do_wr;
    wire do_rd;
    assign in_ready = (cnt_ff != DEPTH);
    assign out_valid = (cnt_ff != {(AW+1){1'b0}});
    assign out_data = mem_ff[rptr_ff];
    assign do_wr = in_valid && in_ready;
    assign do_rd = out_valid && out_ready;
    always @(posedge clk) begin
        if (do_wr) begin
            mem_ff[wptr_ff] <= in_data;
        end
        if (rst) begin
            wptr_ff <= {AW{1'b0}};
            rptr_ff <= {AW{1'b0}};
            cnt_ff <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wptr_ff <= (wptr_ff == DEPTH - 1) ? {AW{1'b0}} : wptr_ff + 1'b1;
            end
            if (do_rd) begin
                rptr_ff <= (rptr_ff == DEPTH - 1) ? {AW{1'b0}} : rptr_ff + 1'b1;
            end
            if (do_wr && !do_rd) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (do_rd && !do_wr) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // pxe_fifo

/* hdl/pxe_top.v */
// Serial-bus slave front end of the sixteen-bit open-drain port expander.
`include "pxe_regs.vh"
module pxe_top (
    input wire mclk,
    input wire sys_rst,
    input wire scl_in,
    input wire sda_in,
    output reg sda_out_ff,
    output reg sda_oe_ff,
    input wire addr_strap_bit0,
    input wire addr_strap_bit1,
    input wire addr_strap_bit2,
    input wire [7:0] low_port_pins_in,
    input wire [7:0] high_port_pins_in,
    output reg [7:0] low_port_pins_out_ff,
    output reg [7:0] low_port_pins_oe_ff,
    output reg [7:0] high_port_pins_out_ff,
    output reg [7:0] high_port_pins_oe_ff,
    output reg busy_ff
);
    localparam ST_IDLE = 6'h01;
    localparam ST_ADDR = 6'h02;
    localparam ST_WDATA = 6'h04;
    localparam ST_RDATA = 6'h08;
    localparam ST_RACK = 6'h10;
    localparam ST_WAIT = 6'h20;

    reg [1:0] scl_sync_ff;
    reg [1:0] sda_sync_ff;
    reg scl_d_ff;
    reg sda_d_ff;
    reg [2:0] strap_s1_ff;
    reg [2:0] strap_s2_ff;
    reg [15:0] pin_s1_ff;
    reg [15:0] pin_s2_ff;
    reg [5:0] state_ff;
    reg [3:0] bit_ff;
    reg [7:0] shift_ff;
    reg ack_phase_ff;
    reg ack_drive_ff;
    reg hi_byte_ff;
    reg [7:0] low_hold_ff;
    reg [7:0] tx_hi_ff;
    reg [15:0] port_ff;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [6:0] my_addr;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [15:0] fifo_out_data;
    wire wr_push;
    wire [15:0] wr_word;

    assign scl_rise = scl_sync_ff[1] && !scl_d_ff;
    assign scl_fall = !scl_sync_ff[1] && scl_d_ff;
    assign start_det = scl_sync_ff[1] && scl_d_ff && sda_d_ff && !sda_sync_ff[1];
    assign stop_det = scl_sync_ff[1] && scl_d_ff && !sda_d_ff && sda_sync_ff[1];
    assign my_addr = {`PXE_ADDR_HI, strap_s2_ff};
    // The second byte of a pair completes a word; a lone first byte never reaches the pins.
    assign wr_push = (state_ff == ST_WDATA) && ack_phase_ff && ack_drive_ff && scl_rise && hi_byte_ff;
    assign wr_word = {shift_ff, low_hold_ff};

    // Received words pass through the FIFO so a full write word lands on the pins two cycles after the push.
    pxe_fifo #(
        .WIDTH(16),
        .DEPTH(`PXE_FIFO_DEPTH),
        .AW(5)
    ) u_fifo (
        .clk(mclk),
        .rst(sys_rst),
        .in_data(wr_word),
        .in_valid(wr_push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );

    always @(posedge mclk) begin
        if (sys_rst) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
            strap_s1_ff <= 3'h0;
            strap_s2_ff <= 3'h0;
            pin_s1_ff <= 16'hFFFF;
            pin_s2_ff <= 16'hFFFF;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_in};
            sda_sync_ff <= {sda_sync_ff[0], sda_in};
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
            strap_s1_ff <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2_ff <= strap_s1_ff;
            pin_s1_ff <= {high_port_pins_in, low_port_pins_in};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // Port latch and open-drain drive.
    always @(posedge mclk) begin
        if (sys_rst) begin
            port_ff <= `PXE_PORT_RST;
            low_port_pins_out_ff <= 8'h00;
            high_port_pins_out_ff <= 8'h00;
            low_port_pins_oe_ff <= 8'h00;
            high_port_pins_oe_ff <= 8'h00;
        end else begin
            if (fifo_out_valid) begin
                port_ff <= fifo_out_data;
            end
            low_port_pins_out_ff <= 8'h00;
            high_port_pins_out_ff <= 8'h00;
            low_port_pins_oe_ff <= ~port_ff[7:0];
            high_port_pins_oe_ff <= ~port_ff[15:8];
        end
    end

    always @(posedge mclk) begin
        if (sys_rst) begin
            state_ff <= ST_IDLE;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            ack_phase_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
            hi_byte_ff <= 1'b0;
            low_hold_ff <= 8'h00;
            tx_hi_ff <= 8'h00;
            sda_out_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (stop_det) begin
            state_ff <= ST_IDLE;
            sda_oe_ff <= 1'b0;
            ack_phase_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
            busy_ff <= 1'b0;
        end else if (start_det) begin
            state_ff <= ST_ADDR;
            bit_ff <= 4'h0;
            ack_phase_ff <= 1'b0;
            ack_drive_ff <= 1'b0;
            hi_byte_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            busy_ff <= 1'b1;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    sda_oe_ff <= 1'b0;
                end
                ST_ADDR, ST_WDATA: begin
                    if (!ack_phase_ff && scl_rise) begin
                        shift_ff <= {shift_ff[6:0], sda_sync_ff[1]};
                        bit_ff <= bit_ff + 4'h1;
                    end else if (!ack_phase_ff && scl_fall && bit_ff == 4'h8) begin
                        ack_phase_ff <= 1'b1;
                        bit_ff <= 4'h0;
                        if (state_ff == ST_ADDR) begin
                            ack_drive_ff <= (shift_ff[7:1] == my_addr) && (shift_ff[7:1] != `PXE_GCALL_ADDR);
                            sda_oe_ff <= (shift_ff[7:1] == my_addr);
                        end else begin
                            ack_drive_ff <= fifo_in_ready;
                            sda_oe_ff <= fifo_in_ready;
                        end
                    end else if (ack_phase_ff && scl_rise && state_ff == ST_WDATA && ack_drive_ff) begin
                        if (!hi_byte_ff) begin
                            low_hold_ff <= shift_ff;
                        end
                        hi_byte_ff <= ~hi_byte_ff;
                    end else if (ack_phase_ff && scl_fall) begin
                        ack_phase_ff <= 1'b0;
                        sda_oe_ff <= 1'b0;
                        if (!ack_drive_ff) begin
                            state_ff <= ST_WAIT;
                        end else if (state_ff == ST_ADDR && shift_ff[0]) begin
                            state_ff <= ST_RDATA;
                            shift_ff <= pin_s2_ff[7:0];
                            tx_hi_ff <= pin_s2_ff[15:8];
                            hi_byte_ff <= 1'b1;
                            sda_oe_ff <= ~pin_s2_ff[7];
                            bit_ff <= 4'h1;
                        end else begin
                            state_ff <= ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (scl_fall) begin
                        if (bit_ff == 4'h8) begin
                            sda_oe_ff <= 1'b0;
                            state_ff <= ST_RACK;
                            bit_ff <= 4'h0;
                        end else begin
                            sda_oe_ff <= ~shift_ff[`PXE_BIT_LAST - bit_ff[2:0]];
                            bit_ff <= bit_ff + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        ack_drive_ff <= !sda_sync_ff[1];
                    end else if (scl_fall) begin
                        if (!ack_drive_ff) begin
                            state_ff <= ST_WAIT;
                        end else begin
                            state_ff <= ST_RDATA;
                            // Low port bytes are sampled fresh; the high byte pairs with its low byte.
                            shift_ff <= hi_byte_ff ? tx_hi_ff : pin_s2_ff[7:0];
                            if (!hi_byte_ff) begin
                                tx_hi_ff <= pin_s2_ff[15:8];
                            end
                            sda_oe_ff <= hi_byte_ff ? ~tx_hi_ff[7] : ~pin_s2_ff[7];
                            hi_byte_ff <= ~hi_byte_ff;
                            bit_ff <= 4'h1;
                        end
                    end
                end
                ST_WAIT: begin
                    sda_oe_ff <= 1'b0;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // pxe_top

/* bench/pxe_top_props.sv */
// Concurrent checks on the port expander's serial and port outputs.
module pxe_top_chk (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out_ff,
    input wire logic sda_oe_ff,
    input wire logic addr_strap_bit0,
    input wire logic addr_strap_bit1,
    input wire logic addr_strap_bit2,
    input wire logic [7:0] low_port_pins_in,
    input wire logic [7:0] high_port_pins_in,
    input wire logic [7:0] low_port_pins_out_ff,
    input wire logic [7:0] low_port_pins_oe_ff,
    input wire logic [7:0] high_port_pins_out_ff,
    input wire logic [7:0] high_port_pins_oe_ff,
    input wire logic busy_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sda_open_a: assert property (sda_out_ff == 1'h0) else $error("sda driven high");
    port_open_a: assert property (low_port_pins_out_ff == 8'h00 && high_port_pins_out_ff == 8'h00)
        else $error("port driven high");
    idle_release_a: assert property (!busy_ff |-> !sda_oe_ff) else $error("sda held while idle");
    start_busy_a: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] busy_ff)
        else $error("start not seen");
    stop_idle_a: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !busy_ff)
        else $error("stop not seen");
    oe_low_phase_a: assert property ($changed(sda_oe_ff) |-> !scl_in) else $error("sda moved in high");
    ack_hold_a: assert property (sda_oe_ff && $rose(scl_in) |-> sda_oe_ff [*5])
        else $error("ack dropped early");
    port_in_txn_a: assert property ($changed({high_port_pins_oe_ff, low_port_pins_oe_ff}) |-> busy_ff)
        else $error("port moved outside transfer");
    reset_idle_a: assert property ($fell(sys_rst) |-> !busy_ff && {high_port_pins_oe_ff, low_port_pins_oe_ff} == 16'h0000)
        else $error("not idle after reset");
endmodule // pxe_top_chk
bind pxe_top pxe_top_chk u_chk (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .addr_strap_bit0(addr_strap_bit0),
    .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit2(addr_strap_bit2), .low_port_pins_in(low_port_pins_in),
    .high_port_pins_in(high_port_pins_in), .low_port_pins_out_ff(low_port_pins_out_ff),
    .low_port_pins_oe_ff(low_port_pins_oe_ff), .high_port_pins_out_ff(high_port_pins_out_ff),
    .high_port_pins_oe_ff(high_port_pins_oe_ff), .busy_ff(busy_ff));

/* bench/pxe_master.sv */
// Bus master model that drives the serial clock and pulls the data line low.
module pxe_master (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'h1;
        sda_lo = 1'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // Data moves two cycles into the low phase, clear of the falling edge.
    task automatic bit_x(input logic b, output logic r);
        wt(2);
        sda_lo <= ~b;
        wt(3);
        scl <= 1'h1;
        wt(5);
        r = sda;
        scl <= 1'h0;
    endtask
    task automatic start_c;
        wt(2);
        sda_lo <= 1'h0;
        wt(3);
        scl <= 1'h1;
        wt(5);
        sda_lo <= 1'h1;
        wt(5);
        scl <= 1'h0;
    endtask
    task automatic stop_c;
        wt(2);
        sda_lo <= 1'h1;
        wt(3);
        scl <= 1'h1;
        wt(5);
        sda_lo <= 1'h0;
        wt(5);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r);
        bit_x(1'h1, r);
        ack = ~r;
    endtask
    task automatic rd_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'h1, r);
            d[i] = r;
        end
        bit_x(~ack, r);
    endtask
endmodule // pxe_master

/* bench/test_i2c_sixteen_bit_port_expander.sv */
// Self-checking bench for the port expander's serial front end.
module test_i2c_sixteen_bit_port_expander;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic [2:0] strap = 3'h0;
    logic [7:0] ext_lo = 8'hFF;
    logic [7:0] ext_hi = 8'hFF;
    logic scl, sda_lo, sda_out_ff, sda_oe_ff, busy_ff;
    logic [7:0] lo_out, lo_oe, hi_out, hi_oe;
    // Pull-up: the line is high unless someone pulls it low.
    wire sda = ~((sda_oe_ff & ~sda_out_ff) | sda_lo);
    int n_fail = 0;
    int samples_checked = 0;
    always #4 mclk = ~mclk;
    pxe_top dut (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out_ff(sda_out_ff),
        .sda_oe_ff(sda_oe_ff), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
        .low_port_pins_in(ext_lo & ~lo_oe), .high_port_pins_in(ext_hi & ~hi_oe), .low_port_pins_out_ff(lo_out),
        .low_port_pins_oe_ff(lo_oe), .high_port_pins_out_ff(hi_out), .high_port_pins_oe_ff(hi_oe), .busy_ff(busy_ff));
    pxe_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_lo(sda_lo));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic t_write;
        logic ak;
        logic r;
        strap <= 3'h5;
        m.start_c();
        chk("busy", 16'h1, {15'h0, busy_ff});
        m.wr_byte(8'h4A, ak);
        chk("addr ack", 16'h1, {15'h0, ak});
        m.wr_byte(8'h0F, ak);
        chk("data ack", 16'h1, {15'h0, ak});
        m.wr_byte(8'hF0, ak);
        m.wr_byte(8'h5A, ak);
        chk("first pair", 16'h0FF0, {hi_oe, lo_oe});
        m.wr_byte(8'hA5, ak);
        m.wr_byte(8'h00, ak);
        m.stop_c();
        m.wt(4);
        chk("overwrite", 16'h5AA5, {hi_oe, lo_oe});
        chk("idle", 16'h0, {15'h0, busy_ff});
        m.start_c();
        m.wr_byte(8'h4A, ak);
        repeat (3) m.bit_x(1'h0, r);
        m.stop_c();
        m.wt(4);
        chk("partial", 16'h5AA5, {hi_oe, lo_oe});
        $display("t_write done");
    endtask
    task automatic t_addr;
        logic ak;
        logic [6:0] bad [4] = '{7'h00, 7'h24, 7'h27, 7'h65};
        for (int i = 0; i < 4; i++) begin
            m.start_c();
            m.wr_byte({bad[i], 1'h0}, ak);
            chk("foreign ack", 16'h0, {15'h0, ak});
            m.wr_byte(8'h00, ak);
            m.wr_byte(8'h00, ak);
            m.stop_c();
            chk("foreign data", 16'h5AA5, {hi_oe, lo_oe});
        end
        $display("t_addr done");
    endtask
    task automatic t_read;
        logic ak;
        logic [7:0] d;
        m.start_c();
        m.wr_byte(8'h4A, ak);
        m.wr_byte(8'hFF, ak);
        m.wr_byte(8'hFF, ak);
        ext_lo <= 8'h3C;
        ext_hi <= 8'hC3;
        m.start_c();
        m.wr_byte(8'h4B, ak);
        m.rd_byte(1'h1, d);
        chk("read low", 16'h003C, {8'h00, d});
        ext_lo <= 8'h81;
        m.rd_byte(1'h1, d);
        chk("read high", 16'h00C3, {8'h00, d});
        m.rd_byte(1'h1, d);
        chk("resample", 16'h0081, {8'h00, d});
        m.rd_byte(1'h0, d);
        chk("release", 16'h0, {15'h0, sda_oe_ff});
        m.stop_c();
        for (int s = 0; s < 8; s++) begin
            strap <= s[2:0];
            m.start_c();
            m.wr_byte({4'h4, s[2:0], 1'h1}, ak);
            chk("strap ack", 16'h1, {15'h0, ak});
            m.rd_byte(1'h1, d);
            m.rd_byte(1'h0, d);
            m.stop_c();
        end
        $display("t_read done");
    endtask
    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'h0;
        m.wt(6);
        chk("reset", 16'h0, {hi_oe, lo_oe} | {15'h0, busy_ff});
        t_write();
        t_addr();
        t_read();
        test_done();
    end
    initial begin
        repeat (40000) @(posedge mclk);
        n_fail++;
        test_done();
    end
endmodule // test_i2c_sixteen_bit_port_expander
